// >>> common/psr_pkg.sv
/*
 * Package for the program space and return stack block: widths, vectors,
 * boot RAM window, register offsets, field positions, reset values and the
 * core request carrier.
 * Assumes one core clock and an APB register bus with 32-bit data.
 */
package psr_pkg;

	localparam int PC_W = 21;
	localparam int SP_W = 5;
	localparam int STACK_DEPTH = 31;
	localparam int DADDR_W = 12;

	// Vectors
	localparam logic [PC_W-1:0] RESET_VECTOR = 21'h000000;
	localparam logic [PC_W-1:0] INT_VECTOR_HIGH = 21'h000008;
	localparam logic [PC_W-1:0] INT_VECTOR_LOW = 21'h000018;
	localparam logic [PC_W-1:0] PC_STEP = 21'h000002;

	// Program space limit of the reduced variant (256K)
	localparam logic [PC_W-1:0] REDUCED_LIMIT = 21'h040000;
	localparam logic [15:0] NOP_WORD = 16'h0000;
	localparam logic [7:0] NOP_BYTE = 8'h00;

	// Boot RAM window
	localparam logic [PC_W-1:0] BOOT_PROG_BASE = 21'h1FFE00;
	localparam logic [DADDR_W-1:0] BOOT_DATA_BASE = 12'h400;
	localparam logic [DADDR_W-1:0] BOOT_DATA_LAST = 12'h5FF;

	localparam logic [SP_W-1:0] SP_MAX = 5'h1F;
	localparam logic [SP_W-1:0] SP_RESET = 5'h00;

	// Register byte offsets
	localparam logic [11:0] OFS_STACK_POINTER = 12'h000;
	localparam logic [11:0] OFS_TOS_LOW = 12'h004;
	localparam logic [11:0] OFS_TOS_HIGH = 12'h008;
	localparam logic [11:0] OFS_TOS_UPPER = 12'h00C;
	localparam logic [11:0] OFS_MEMORY_CONTROL = 12'h010;
	localparam logic [11:0] OFS_CONFIG_FOUR_LOW = 12'h014;
	localparam logic [11:0] OFS_PC_STATUS = 12'h018;

	// Field positions
	localparam int BIT_STACK_FULL = 7;
	localparam int BIT_STACK_UNDERFLOW = 6;
	localparam int BIT_REMAP = 0;
	localparam int BIT_STACK_ERROR_RESET_ENABLE = 0;
	localparam int BIT_BOOT_EXEC = 21;

	// Reset values
	localparam logic RESET_REMAP = 1'b0;
	localparam logic RESET_STACK_ERROR_RESET_ENABLE = 1'b1;

	typedef enum logic [3:0] {
		OP_NONE,
		OP_STEP,
		OP_JUMP,
		OP_PUSH,
		OP_CALL,
		OP_RELATIVE_CALL,
		OP_INT_ACK,
		OP_RETURN,
		OP_RETURN_WITH_LITERAL,
		OP_RETURN_FROM_INTERRUPT,
		OP_POP
	} psr_op_t;

	typedef struct packed {
		psr_op_t op;
		logic [PC_W-1:0] target;
		logic int_high;
	} psr_core_req_t;

	function automatic logic psr_in_range(input logic [PC_W-1:0] a,
		input logic [PC_W-1:0] lo);
		psr_in_range = (a >= lo);
	endfunction

	function automatic logic psr_is_push(input psr_op_t op);
		psr_is_push = (op == OP_PUSH) || (op == OP_CALL) ||
			(op == OP_RELATIVE_CALL) || (op == OP_INT_ACK);
	endfunction

	function automatic logic psr_is_return(input psr_op_t op);
		psr_is_return = (op == OP_RETURN) || (op == OP_RETURN_WITH_LITERAL) ||
			(op == OP_RETURN_FROM_INTERRUPT);
	endfunction

endpackage

// >>> src/psr_stack_mem.sv
/*
 * Return stack storage: DEPTH words, entry 0 has no storage and reads 0.
 * Read data is registered from the next read address, with write-through.
 * Assumes the caller presents the next pointer as both addresses.
 */
`timescale 1ns/1ps
module psr_stack_mem
	import psr_pkg::*;
#(
	parameter int DEPTH = STACK_DEPTH,
	parameter int W = PC_W,
	parameter int AW = SP_W
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Write port
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [W-1:0] wdata,
	// Read port
	input wire logic [AW-1:0] raddr,
	output logic [W-1:0] rdata_q
);

	logic [W-1:0] mem [1:DEPTH];

	// Index 0 is only a reset value, never stored
	always_ff @(posedge clk)
	begin
		if (we && (waddr != '0))
		begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rdata_q <= '0;
		end
		else if (raddr == '0)
		begin
			rdata_q <= '0;
		end
		else if (we && (waddr == raddr))
		begin
			rdata_q <= wdata;
		end
		else
		begin
			rdata_q <= mem[raddr];
		end
	end

endmodule // psr_stack_mem

// >>> src/psr_addr_map.sv
/*
 * Program address decode: reduced variant limit and boot RAM window.
 * Purely combinational; assumes addresses come from registers upstream.
 */
`timescale 1ns/1ps
module psr_addr_map
	import psr_pkg::*;
#(
	parameter bit REDUCED = 1'b0
)
(
	// Addresses
	input wire logic [PC_W-1:0] fetch_addr,
	input wire logic [PC_W-1:0] tbl_addr,
	input wire logic remap,
	// Decode results
	output logic fetch_beyond,
	output logic tbl_beyond,
	output logic fetch_in_boot,
	output logic [DADDR_W-1:0] boot_ram_addr
);

	assign fetch_beyond = REDUCED && psr_in_range(fetch_addr, REDUCED_LIMIT);
	assign tbl_beyond = REDUCED && psr_in_range(tbl_addr, REDUCED_LIMIT);
	assign fetch_in_boot = remap && psr_in_range(fetch_addr, BOOT_PROG_BASE);
	assign boot_ram_addr = BOOT_DATA_BASE + {3'h0, fetch_addr[8:0]};

endmodule // psr_addr_map

// >>> src/psr_top.sv
/*
 * Program space mapping and return address stack of an 8-bit core:
 * program counter, vectors, boot RAM remap, hardware return stack and
 * its APB register view.
 * Assumes the core presents one request per clock and synchronous inputs.
 */
// Functional notes
// - Keep a 21-bit byte program counter over a 2 Mbyte space.
// - Reduced variant returns NOPs for table reads or non-boot-window fetches beyond 256K.
// - Execution starts at 000000h; interrupts vector to 000008h or 000018h.
// - Remap bit set maps data 400h-5FFh onto program 1FFE00h-1FFFFFh.
// - With remap set, data reads of 400h-5FFh return zero.
// - With remap set, data writes to that RAM change nothing.
// - Table writes to boot addresses go to the external bus only; here they are dropped while executing from boot RAM.
// - Table reads from boot addresses come from the external bus; the reduced variant returns NOPs.
// - Remap bit resets to 0; software sets and clears it freely.
// - External bus is idle while executing from boot RAM.
// - Push on push, call, relative call, interrupt; pop on returns.
// - Stack of 31 by 21 bits; pointer resets to 0, no entry 0.
// - Push increments then writes; pop reads then decrements.
// - Three byte registers read and write the entry at the pointer.
// - Software reads and writes the pointer 0 to 31.
// - Thirty-one pushes set the full flag; only software or reset clear it.
// - Error reset option on: overflow or underflow sets flag and resets.
// - Option off: 31st push sets full, pointer 31, later pushes ignored.
// - Return at pointer 0 loads PC zero, sets underflow, keeps pointer 0.
// - Pointer register: full bit 7, underflow bit 6, bit 5 zero, pointer.
`timescale 1ns/1ps
module psr_top
	import psr_pkg::*;
#(
	parameter bit REDUCED = 1'b0
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Core sequencing
	input wire psr_core_req_t core_req,
	output logic [PC_W-1:0] pc_q,
	output logic stack_reset_q,
	// Instruction fetch
	input wire logic [15:0] ext_fetch_data,
	input wire logic [15:0] boot_fetch_data,
	output logic boot_fetch_sel,
	output logic [DADDR_W-1:0] boot_ram_addr,
	output logic [15:0] instr_q,
	// Table access
	input wire logic [PC_W-1:0] tbl_addr,
	input wire logic tbl_wr,
	input wire logic [7:0] ext_tbl_data,
	output logic ext_tbl_wr,
	output logic [7:0] tbl_data_q,
	// Data space access to the shared RAM
	input wire logic [DADDR_W-1:0] dmem_addr,
	input wire logic dmem_we,
	input wire logic [7:0] dmem_rdata_in,
	output logic dmem_we_out,
	output logic [7:0] dmem_rdata_q,
	// External system bus control
	output logic ext_bus_en
);

	logic [SP_W-1:0] sp_q;
	logic [SP_W-1:0] sp_d;
	logic full_q;
	logic unf_q;
	logic remap_q;
	logic stack_error_reset_enable_q;
	logic [PC_W-1:0] tos;
	logic mem_we;
	logic [PC_W-1:0] mem_wdata;
	logic is_push;
	logic is_ret;
	logic is_pop;
	logic stack_op;
	logic overflow;
	logic underflow;
	logic err_reset;
	logic fetch_beyond;
	logic tbl_beyond;
	logic fetch_in_boot;
	logic dmem_in_boot;
	logic access;
	logic stack_reg;
	logic wr_ok;
	logic sel_sp;
	logic sel_tl;
	logic sel_th;
	logic sel_tu;
	logic sel_mc;
	logic sel_cf;
	logic sel_pc;
	logic mapped;
	logic [PC_W-1:0] tos_new;

	assign is_push = psr_is_push(core_req.op);
	assign is_ret = psr_is_return(core_req.op);
	assign is_pop = is_ret || (core_req.op == OP_POP);
	assign stack_op = is_push || is_pop;
	assign overflow = is_push && (sp_q == SP_MAX);
	assign underflow = is_pop && (sp_q == SP_RESET);
	assign err_reset = stack_error_reset_enable_q && (overflow || underflow);

	// APB decode
	assign access = psel && penable;
	assign sel_sp = (paddr == OFS_STACK_POINTER);
	assign sel_tl = (paddr == OFS_TOS_LOW);
	assign sel_th = (paddr == OFS_TOS_HIGH);
	assign sel_tu = (paddr == OFS_TOS_UPPER);
	assign sel_mc = (paddr == OFS_MEMORY_CONTROL);
	assign sel_cf = (paddr == OFS_CONFIG_FOUR_LOW);
	assign sel_pc = (paddr == OFS_PC_STATUS);
	assign mapped = sel_sp || sel_tl || sel_th || sel_tu || sel_mc ||
		sel_cf || sel_pc;
	assign stack_reg = sel_sp || sel_tl || sel_th || sel_tu;
	// Stall software stack edits rather than race a core stack operation
	assign pready = !(psel && stack_reg && stack_op);
	assign pslverr = access && !mapped;
	assign wr_ok = access && pready && pwrite && mapped;

	// Next pointer
	always_comb
	begin
		sp_d = sp_q;
		if (err_reset)
		begin
			sp_d = SP_RESET;
		end
		else if (is_push)
		begin
			if (sp_q != SP_MAX)
			begin
				sp_d = sp_q + 5'h01;
			end
		end
		else if (is_pop)
		begin
			if (sp_q != SP_RESET)
			begin
				sp_d = sp_q - 5'h01;
			end
		end
		else if (wr_ok && sel_sp)
		begin
			sp_d = pwdata[SP_W-1:0];
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sp_q <= SP_RESET;
		end
		else
		begin
			sp_q <= sp_d;
		end
	end

	// Top of stack byte merge
	always_comb
	begin
		tos_new = tos;
		if (sel_tl)
		begin
			tos_new[7:0] = pwdata[7:0];
		end
		else if (sel_th)
		begin
			tos_new[15:8] = pwdata[7:0];
		end
		else if (sel_tu)
		begin
			tos_new[20:16] = pwdata[4:0];
		end
	end

	// Write address is always the next pointer, so push writes sp_q+1
	assign mem_we = (is_push && !overflow) ||
		(!stack_op && wr_ok && (sel_tl || sel_th || sel_tu));
	assign mem_wdata = is_push ? pc_q : tos_new;

	psr_stack_mem #(
		.DEPTH(STACK_DEPTH),
		.W(PC_W),
		.AW(SP_W)
	) u_stack (
		.clk(clk),
		.nrst(nrst),
		.we(mem_we),
		.waddr(sp_d),
		.wdata(mem_wdata),
		.raddr(sp_d),
		.rdata_q(tos)
	);

	// Full flag: set beats a software clear in the same cycle
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			full_q <= 1'b0;
		end
		else if (is_push && (sp_q >= SP_MAX - 5'h01))
		begin
			full_q <= 1'b1;
		end
		else if (wr_ok && sel_sp && !pwdata[BIT_STACK_FULL])
		begin
			full_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			unf_q <= 1'b0;
		end
		else if (underflow)
		begin
			unf_q <= 1'b1;
		end
		else if (wr_ok && sel_sp && !pwdata[BIT_STACK_UNDERFLOW])
		begin
			unf_q <= 1'b0;
		end
	end

	// Device reset request after a stack error
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			stack_reset_q <= 1'b0;
		end
		else
		begin
			stack_reset_q <= err_reset;
		end
	end

	// Configuration bits
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			remap_q <= RESET_REMAP;
			stack_error_reset_enable_q <= RESET_STACK_ERROR_RESET_ENABLE;
		end
		else
		begin
			if (wr_ok && sel_mc)
			begin
				remap_q <= pwdata[BIT_REMAP];
			end
			if (wr_ok && sel_cf)
			begin
				stack_error_reset_enable_q <= pwdata[BIT_STACK_ERROR_RESET_ENABLE];
			end
		end
	end

	// Program counter; returns touch no PC latch, none is kept here
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pc_q <= RESET_VECTOR;
		end
		else if (err_reset)
		begin
			pc_q <= RESET_VECTOR;
		end
		else
		begin
			case (core_req.op)
				OP_STEP:
				begin
					pc_q <= pc_q + PC_STEP;
				end
				OP_JUMP, OP_CALL, OP_RELATIVE_CALL:
				begin
					pc_q <= {core_req.target[PC_W-1:1], 1'b0};
				end
				OP_INT_ACK:
				begin
					pc_q <= core_req.int_high ? INT_VECTOR_HIGH :
						INT_VECTOR_LOW;
				end
				OP_RETURN, OP_RETURN_WITH_LITERAL, OP_RETURN_FROM_INTERRUPT:
				begin
					// Entry 0 reads zero, so underflow lands on reset vector
					pc_q <= {tos[PC_W-1:1], 1'b0};
				end
				default:
				begin
					pc_q <= pc_q;
				end
			endcase
		end
	end

	psr_addr_map #(
		.REDUCED(REDUCED)
	) u_map (
		.fetch_addr(pc_q),
		.tbl_addr(tbl_addr),
		.remap(remap_q),
		.fetch_beyond(fetch_beyond),
		.tbl_beyond(tbl_beyond),
		.fetch_in_boot(fetch_in_boot),
		.boot_ram_addr(boot_ram_addr)
	);

	assign boot_fetch_sel = fetch_in_boot;
	assign ext_bus_en = !fetch_in_boot;
	// Table writes never reach boot RAM
	assign ext_tbl_wr = tbl_wr && !fetch_in_boot;

	// Fetched instruction, one cycle behind the PC
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			instr_q <= NOP_WORD;
		end
		else if (fetch_in_boot)
		begin
			instr_q <= boot_fetch_data;
		end
		else if (fetch_beyond)
		begin
			instr_q <= NOP_WORD;
		end
		else
		begin
			instr_q <= ext_fetch_data;
		end
	end

	// Table reads never use boot RAM; the reduced variant returns NOP beyond 256K, boot window included
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			tbl_data_q <= NOP_BYTE;
		end
		else
		begin
			tbl_data_q <= tbl_beyond ? NOP_BYTE : ext_tbl_data;
		end
	end

	// Data space view of the remapped RAM
	assign dmem_in_boot = remap_q && (dmem_addr >= BOOT_DATA_BASE) &&
		(dmem_addr <= BOOT_DATA_LAST);
	assign dmem_we_out = dmem_we && !dmem_in_boot;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			dmem_rdata_q <= 8'h00;
		end
		else
		begin
			dmem_rdata_q <= dmem_in_boot ? 8'h00 : dmem_rdata_in;
		end
	end

	// Register read mux; unmapped reads return zero
	always_comb
	begin
		prdata = 32'h00000000;
		if (sel_sp)
		begin
			prdata = {24'h000000, full_q, unf_q, 1'b0, sp_q};
		end
		else if (sel_tl)
		begin
			prdata = {24'h000000, tos[7:0]};
		end
		else if (sel_th)
		begin
			prdata = {24'h000000, tos[15:8]};
		end
		else if (sel_tu)
		begin
			prdata = {27'h0000000, tos[20:16]};
		end
		else if (sel_mc)
		begin
			prdata = {31'h00000000, remap_q};
		end
		else if (sel_cf)
		begin
			prdata = {31'h00000000, stack_error_reset_enable_q};
		end
		else if (sel_pc)
		begin
			prdata = {10'h000, fetch_in_boot, pc_q};
		end
	end

endmodule // psr_top

// >>> tb/psr_mem_model.sv
/*
 * Far-side memory model: external program, table and data RAM read data.
 * Assumes the block presents registered addresses once per clock.
 */
`timescale 1ns/1ps
module psr_mem_model
	import psr_pkg::*;
(
	// Addresses from the block
	input wire logic [PC_W-1:0] pc_q,
	input wire logic [DADDR_W-1:0] boot_ram_addr,
	input wire logic [PC_W-1:0] tbl_addr,
	input wire logic [DADDR_W-1:0] dmem_addr,
	// Read data back
	output logic [15:0] ext_fetch_data,
	output logic [15:0] boot_fetch_data,
	output logic [7:0] ext_tbl_data,
	output logic [7:0] dmem_rdata_in
);
	// Never zero, so a forced NOP or blanked read stands out
	assign ext_fetch_data = pc_q[15:0] | 16'h0001;
	assign boot_fetch_data = {4'hB, boot_ram_addr};
	assign ext_tbl_data = tbl_addr[7:0] | 8'h01;
	assign dmem_rdata_in = {1'b1, dmem_addr[6:0]};
endmodule // psr_mem_model

// >>> tb/psr_top_sva.sv
/*
 * Checker for psr_top: program counter, boot window and bus rules.
 * Assumes it is bound to psr_top and sees only its ports.
 */
`timescale 1ns/1ps
module psr_top_sva
	import psr_pkg::*;
#(
	parameter bit REDUCED = 1'b0
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Observed ports
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic pslverr,
	input wire psr_core_req_t core_req,
	input wire logic [PC_W-1:0] pc_q,
	input wire logic [15:0] instr_q,
	input wire logic boot_fetch_sel,
	input wire logic ext_bus_en,
	input wire logic [PC_W-1:0] tbl_addr,
	input wire logic tbl_wr,
	input wire logic ext_tbl_wr,
	input wire logic [7:0] tbl_data_q,
	input wire logic [DADDR_W-1:0] dmem_addr,
	input wire logic dmem_we,
	input wire logic dmem_we_out
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	a_reset_vector: assert property (
		$rose(nrst) |-> pc_q == RESET_VECTOR) else $error("bad reset pc");
	a_step_pc: assert property (
		core_req.op == OP_STEP |=> pc_q == $past(pc_q) + PC_STEP)
		else $error("pc step wrong");
	// Overflow resets may zero the pc instead
	a_call_target: assert property (
		core_req.op == OP_CALL |=> pc_q == $past(core_req.target)
		|| pc_q == RESET_VECTOR) else $error("call target lost");
	a_int_vector: assert property (
		core_req.op == OP_INT_ACK |=> pc_q == RESET_VECTOR ||
		pc_q == ($past(core_req.int_high) ? INT_VECTOR_HIGH :
		INT_VECTOR_LOW)) else $error("bad interrupt vector");
	a_call_return: assert property (
		core_req.op == OP_CALL ##1 core_req.op == OP_RETURN |=>
		pc_q == $past(pc_q, 2)) else $error("return address wrong");
	a_boot_range: assert property (
		boot_fetch_sel |-> pc_q >= BOOT_PROG_BASE)
		else $error("boot select outside window");
	a_bus_idle: assert property (
		ext_bus_en == !boot_fetch_sel) else $error("bus enable wrong");
	a_tbl_write_ext: assert property (
		tbl_wr && ext_bus_en |-> ext_tbl_wr) else $error("table write lost");
	a_dmem_pass: assert property (
		dmem_we && (dmem_addr < BOOT_DATA_BASE || dmem_addr > BOOT_DATA_LAST)
		|-> dmem_we_out) else $error("data write blocked");
	// Boot RAM is on chip, so its window is exempt from the NOP fill
	a_fetch_nop: assert property (
		REDUCED && pc_q >= REDUCED_LIMIT && !boot_fetch_sel |=>
		instr_q == NOP_WORD)
		else $error("fetch beyond limit not NOP");
	a_tbl_nop: assert property (
		REDUCED && tbl_addr >= REDUCED_LIMIT |=> tbl_data_q == NOP_BYTE)
		else $error("table read beyond limit not zero");
	a_unmapped_err: assert property (
		psel && penable && paddr > OFS_PC_STATUS |-> pslverr)
		else $error("unmapped access without error");

	c_call_ret: cover property (core_req.op == OP_CALL ##1
		core_req.op == OP_RETURN);
	c_boot_exec: cover property (boot_fetch_sel);
	c_tbl_ext: cover property (ext_tbl_wr);
endmodule // psr_top_sva

bind psr_top psr_top_sva #(.REDUCED(REDUCED)) u_sva (.clk(clk), .nrst(nrst),
	.psel(psel), .penable(penable), .paddr(paddr), .pslverr(pslverr),
	.core_req(core_req), .pc_q(pc_q), .instr_q(instr_q),
	.boot_fetch_sel(boot_fetch_sel), .ext_bus_en(ext_bus_en),
	.tbl_addr(tbl_addr), .tbl_wr(tbl_wr), .ext_tbl_wr(ext_tbl_wr),
	.tbl_data_q(tbl_data_q), .dmem_addr(dmem_addr), .dmem_we(dmem_we),
	.dmem_we_out(dmem_we_out));

// >>> tb/testbench.sv
/*
 * Self-checking testbench for psr_top, reduced variant, over APB and ops.
 * Assumes psr_mem_model answers reads and the checker is bound.
 */
`timescale 1ns/1ps
module testbench;
	import psr_pkg::*;
	logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, pready, pslverr, err, srst, boot_sel, ext_tbl_wr;
	logic tbl_wr = 1'b0, dmem_we = 1'b0, dmem_we_out, ext_bus_en, seen;
	logic [11:0] paddr = 12'h000, dmem_addr = 12'h000, boot_addr;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [PC_W-1:0] pc_q, tbl_addr = 21'h0;
	logic [15:0] ext_fd, boot_fd, instr_q;
	logic [7:0] ext_td, tbl_data_q, dmem_rin, dmem_rdata_q;
	psr_core_req_t core_req = '0;
	int bad_count = 0, num_checks = 0, cycles = 0;

	psr_top #(.REDUCED(1'b1)) uut (.clk(clk), .nrst(nrst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.core_req(core_req), .pc_q(pc_q), .stack_reset_q(srst),
		.ext_fetch_data(ext_fd), .boot_fetch_data(boot_fd),
		.boot_fetch_sel(boot_sel), .boot_ram_addr(boot_addr),
		.instr_q(instr_q), .tbl_addr(tbl_addr), .tbl_wr(tbl_wr),
		.ext_tbl_data(ext_td), .ext_tbl_wr(ext_tbl_wr),
		.tbl_data_q(tbl_data_q), .dmem_addr(dmem_addr), .dmem_we(dmem_we),
		.dmem_rdata_in(dmem_rin), .dmem_we_out(dmem_we_out),
		.dmem_rdata_q(dmem_rdata_q), .ext_bus_en(ext_bus_en));
	psr_mem_model mem (.pc_q(pc_q), .boot_ram_addr(boot_addr),
		.tbl_addr(tbl_addr), .dmem_addr(dmem_addr), .ext_fetch_data(ext_fd),
		.boot_fetch_data(boot_fd), .ext_tbl_data(ext_td),
		.dmem_rdata_in(dmem_rin));

	always #5 clk = ~clk;

	task automatic summarize;
		$display("Checks %0d, mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Far above the roughly 160 cycles the sequence needs
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			$display("ERROR %0t: timeout", $time);
			bad_count++;
			summarize;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
			bad_count++;
		end
	endtask

	// Data taken at the edge that completes the access, then released
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	task automatic op(input psr_op_t o, input logic [20:0] t, input logic h);
		@(posedge clk);
		core_req <= {o, t, h};
	endtask

	task automatic idle;
		@(posedge clk);
		core_req <= '0;
		#1;
	endtask

	initial
	begin
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		idle;
		chk(pc_q, 32'h0);
		rchk(OFS_STACK_POINTER, 32'h0);
		rchk(OFS_MEMORY_CONTROL, 32'h0);
		rchk(OFS_CONFIG_FOUR_LOW, 32'h1);
		apb(1'b0, 12'h01C, 32'h0);
		chk(err, 32'h1);
		op(OP_JUMP, 21'h000100, 1'b0);
		op(OP_CALL, 21'h000200, 1'b0);
		op(OP_CALL, 21'h000300, 1'b0);
		idle;
		chk(pc_q, 32'h300);
		rchk(OFS_STACK_POINTER, 32'h02);
		rchk(OFS_TOS_HIGH, 32'h02);
		apb(1'b1, OFS_TOS_LOW, 32'h40);
		op(OP_RETURN, 21'h0, 1'b0);
		idle;
		chk(pc_q, 32'h240);
		op(OP_CALL, 21'h000500, 1'b0);
		op(OP_RETURN, 21'h0, 1'b0);
		op(OP_RETURN, 21'h0, 1'b0);
		idle;
		chk(pc_q, 32'h100);
		op(OP_INT_ACK, 21'h0, 1'b1);
		idle;
		chk(pc_q, 32'h008);
		op(OP_INT_ACK, 21'h0, 1'b0);
		idle;
		chk(pc_q, 32'h018);
		op(OP_RETURN_FROM_INTERRUPT, 21'h0, 1'b0);
		op(OP_RETURN_WITH_LITERAL, 21'h0, 1'b0);
		op(OP_RELATIVE_CALL, 21'h000400, 1'b0);
		op(OP_POP, 21'h0, 1'b0);
		idle;
		chk(pc_q, 32'h400);
		rchk(OFS_STACK_POINTER, 32'h0);
		apb(1'b1, OFS_CONFIG_FOUR_LOW, 32'h0);
		op(OP_RETURN, 21'h0, 1'b0);
		idle;
		chk(pc_q, 32'h0);
		rchk(OFS_STACK_POINTER, 32'h40);
		apb(1'b1, OFS_STACK_POINTER, 32'h0);
		rchk(OFS_STACK_POINTER, 32'h0);
		repeat (STACK_DEPTH) op(OP_PUSH, 21'h0, 1'b0);
		idle;
		rchk(OFS_STACK_POINTER, 32'h9F);
		op(OP_PUSH, 21'h0, 1'b0);
		idle;
		rchk(OFS_STACK_POINTER, 32'h9F);
		apb(1'b1, OFS_STACK_POINTER, 32'h85);
		rchk(OFS_STACK_POINTER, 32'h85);
		apb(1'b1, OFS_STACK_POINTER, 32'h9F);
		apb(1'b1, OFS_CONFIG_FOUR_LOW, 32'h1);
		op(OP_PUSH, 21'h0, 1'b0);
		idle;
		seen = srst;
		@(posedge clk);
		#1;
		chk({seen, srst}, 32'h2);
		rchk(OFS_STACK_POINTER, 32'h80);
		// Read stalls behind two pushes, so it sees the pointer after both
		fork
			apb(1'b0, OFS_STACK_POINTER, 32'h0);
			begin
				op(OP_PUSH, 21'h0, 1'b0);
				op(OP_PUSH, 21'h0, 1'b0);
				idle;
			end
		join
		chk(rd, 32'h82);
		apb(1'b1, OFS_MEMORY_CONTROL, 32'h1);
		rchk(OFS_MEMORY_CONTROL, 32'h1);
		@(posedge clk);
		dmem_addr <= 12'h400;
		dmem_we <= 1'b1;
		#1;
		chk(dmem_we_out, 32'h0);
		@(posedge clk);
		dmem_addr <= 12'h3FF;
		#1;
		chk(dmem_we_out, 32'h1);
		chk(dmem_rdata_q, 32'h0);
		@(posedge clk);
		dmem_we <= 1'b0;
		#1;
		chk(dmem_rdata_q, 32'hFF);
		op(OP_JUMP, BOOT_PROG_BASE, 1'b0);
		op(OP_STEP, 21'h0, 1'b0);
		idle;
		chk(boot_sel, 32'h1);
		chk(ext_bus_en, 32'h0);
		chk(boot_addr, 32'h402);
		op(OP_JUMP, 21'h000100, 1'b0);
		idle;
		chk(ext_bus_en, 32'h1);
		@(posedge clk);
		tbl_addr <= BOOT_PROG_BASE;
		tbl_wr <= 1'b1;
		#1;
		chk(ext_tbl_wr, 32'h1);
		@(posedge clk);
		tbl_addr <= REDUCED_LIMIT;
		tbl_wr <= 1'b0;
		@(posedge clk);
		tbl_addr <= 21'h000123;
		#1;
		chk(tbl_data_q, 32'h0);
		@(posedge clk);
		#1;
		chk(tbl_data_q, 32'h23);
		apb(1'b1, OFS_MEMORY_CONTROL, 32'h0);
		op(OP_JUMP, REDUCED_LIMIT, 1'b0);
		idle;
		chk(boot_sel, 32'h0);
		@(posedge clk);
		#1;
		chk(instr_q, 32'h0);
		op(OP_JUMP, 21'h03FFFE, 1'b0);
		idle;
		@(posedge clk);
		#1;
		chk(instr_q, 32'hFFFF);
		summarize;
	end
endmodule // testbench
